// *** rtl/uams_top.v ***
// measurement sequencer: state machine, tx burst, echo stop, temperature
`timescale 1ns/1ps
`default_nettype none
`include "uams_defs.vh"
module uams_top #(
  parameter CNT_W = 16,
  parameter TX_HALF = 8'h04,
  parameter TIMEOUT_CYC = 16'h4000
) (
  // clock, reset, enable
  input wire clock,
  input wire rstn,
  input wire ce,
  // pins from host
  input wire wake_pin,
  input wire trigger_pin,
  input wire reset_pin,
  // configuration
  input wire measurement_select,
  input wire trig_falling_select,
  input wire temp_clock_divider_select,
  input wire [7:0] tx_clock_div,
  input wire single_rtd_select,
  input wire rtd_type_select,
  input wire [4:0] tx_pulse_count,
  input wire phase_flip_enable,
  input wire [4:0] phase_flip_position,
  input wire tail_stretch_enable,
  input wire echo_grouping_select,
  input wire [2:0] expected_stop_count,
  input wire [2:0] qualify_threshold_level,
  // analogue interface
  input wire zero_cross,
  input wire above_threshold,
  input wire [CNT_W-1:0] rtd_ref_cycles,
  input wire [CNT_W-1:0] rtd1_cycles,
  input wire [CNT_W-1:0] rtd2_cycles,
  // outputs
  output reg tx_out,
  output reg start_out,
  output reg stop_out,
  output reg error_n,
  output reg [2:0] threshold_dac,
  output reg config_ready,
  output reg busy,
  output reg [2:0] state_out
);
  wire wake_s;
  wire trig_s;
  wire zc_s;
  wire thr_s;
  wire rst_s;
  uams_sync u_wake (.clock(clock), .rstn(rstn), .ce(ce), .din(wake_pin),
    .dout(wake_s));
  uams_sync u_trig (.clock(clock), .rstn(rstn), .ce(ce), .din(trigger_pin),
    .dout(trig_s));
  uams_sync u_zc (.clock(clock), .rstn(rstn), .ce(ce), .din(zero_cross),
    .dout(zc_s));
  uams_sync u_thr (.clock(clock), .rstn(rstn), .ce(ce),
    .din(above_threshold), .dout(thr_s));
  uams_sync u_rst (.clock(clock), .rstn(rstn), .ce(ce), .din(reset_pin),
    .dout(rst_s));

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg trig_d_r;
  reg zc_d_r;
  reg booted_r;
  // tx
  reg [7:0] tdiv_r;
  reg [5:0] half_r;
  reg phase_r;
  reg stretch_r;
  // rx
  reg armed_r;
  reg [2:0] stops_r;
  reg [CNT_W-1:0] tmo_r;
  reg group_r;
  // temperature
  reg [7:0] tclk_r;
  reg [1:0] ival_r;
  reg gap_r;
  reg [CNT_W+5:0] tcnt_r;
  // constants at the width of the logic they meet
  localparam [7:0] TEMP_DIV = `UAMS_TEMP_DIV;
  localparam [CNT_W+5:0] GAP_BASE = `UAMS_TEMP_GAP_BASE;
  localparam [CNT_W+5:0] GAP_NUM = `UAMS_TEMP_GAP_NUM;
  localparam [CNT_W+5:0] GAP_DEN = `UAMS_TEMP_GAP_DEN;

  wire trig_edge = trig_falling_select ? (trig_d_r & ~trig_s)
                                       : (~trig_d_r & trig_s);
  wire zc_rise = zc_s & ~zc_d_r;
  wire abort = rst_s | ~wake_s;
  wire [7:0] tdiv_lim = temp_clock_divider_select ? tx_clock_div
                                                  : TEMP_DIV;
  wire ttick = (tclk_r == tdiv_lim - 8'h01);
  wire [5:0] half_total = {tx_pulse_count, 1'b0};
  wire flip_on = phase_flip_enable &&
                 (phase_flip_position != `UAMS_PH_FLIP_OFF);

  // interval length by index, honouring single sensor ordering
  function [CNT_W-1:0] ival_len;
    input [1:0] idx;
    begin
      if (idx == 2'h2)
        ival_len = single_rtd_select ? rtd1_cycles : rtd2_cycles;
      else if (idx == 2'h1)
        ival_len = single_rtd_select ? rtd_ref_cycles : rtd1_cycles;
      else
        ival_len = rtd_ref_cycles;
    end
  endfunction

  // gap: 51 temperature clocks plus 0.55 of the prior interval, in ticks
  function [CNT_W+5:0] gap_len;
    input [CNT_W-1:0] prev;
    begin
      gap_len = GAP_BASE +
        (({6'h00, prev} * GAP_NUM) / GAP_DEN);
    end
  endfunction

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `UAMS_ST_SLEEP: begin
        if (booted_r && wake_s)
          state_nxt = `UAMS_ST_READY;
      end
      `UAMS_ST_READY: begin
        if (!wake_s)
          state_nxt = `UAMS_ST_SLEEP;
        else if (trig_edge && !rst_s)
          state_nxt = measurement_select ? `UAMS_ST_TEMP
                                         : `UAMS_ST_TX;
      end
      `UAMS_ST_TX: begin
        if (abort)
          state_nxt = `UAMS_ST_SLEEP;
        else if (tdiv_r == 8'h00 && half_r == 6'h00)
          state_nxt = `UAMS_ST_RX;
      end
      `UAMS_ST_RX: begin
        if (abort)
          state_nxt = `UAMS_ST_SLEEP;
        else if (stops_r == expected_stop_count && !stop_out)
          state_nxt = `UAMS_ST_DONE;
        else if (tmo_r == {CNT_W{1'b0}})
          state_nxt = `UAMS_ST_DONE;
      end
      `UAMS_ST_TEMP: begin
        if (abort)
          state_nxt = `UAMS_ST_SLEEP;
        else if (ttick && tcnt_r == 0 && gap_r &&
                 ival_r == `UAMS_TEMP_INTERVALS - 1)
          state_nxt = `UAMS_ST_DONE;
      end
      `UAMS_ST_DONE: state_nxt = `UAMS_ST_SLEEP;
      default: state_nxt = `UAMS_ST_SLEEP;
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= `UAMS_ST_SLEEP;
      trig_d_r <= 1'b0;
      zc_d_r <= 1'b0;
      booted_r <= 1'b0;
      tdiv_r <= 8'h00;
      half_r <= 6'h00;
      phase_r <= 1'b0;
      stretch_r <= 1'b0;
      armed_r <= 1'b0;
      stops_r <= 3'h0;
      tmo_r <= {CNT_W{1'b0}};
      group_r <= 1'b0;
      tclk_r <= 8'h00;
      ival_r <= 2'h0;
      gap_r <= 1'b0;
      tcnt_r <= {(CNT_W+6){1'b0}};
      tx_out <= 1'b0;
      start_out <= 1'b0;
      stop_out <= 1'b0;
      error_n <= 1'b1;
      threshold_dac <= 3'h0;
      config_ready <= 1'b0;
      busy <= 1'b0;
      state_out <= `UAMS_ST_SLEEP;
    end else if (ce) begin
      // wake level is only trusted once the filter has settled
      booted_r <= 1'b1;
      trig_d_r <= trig_s;
      zc_d_r <= zc_s;
      state_r <= state_nxt;
      state_out <= state_nxt;
      threshold_dac <= qualify_threshold_level;
      config_ready <= (state_nxt == `UAMS_ST_SLEEP) ||
                      (state_nxt == `UAMS_ST_READY);
      busy <= (state_nxt != `UAMS_ST_SLEEP) &&
              (state_nxt != `UAMS_ST_READY);
      if (state_r == `UAMS_ST_READY && state_nxt != `UAMS_ST_READY &&
          state_nxt != `UAMS_ST_SLEEP) begin
        // launch: one pulse cycle is two half periods
        error_n <= 1'b1;
        tdiv_r <= TX_HALF;
        // the flip merges two high halves, which drops one pulse
        half_r <= half_total;
        phase_r <= 1'b0;
        stretch_r <= 1'b0;
        tx_out <= 1'b0;
        start_out <= 1'b1;
        stops_r <= 3'h0;
        armed_r <= 1'b0;
        group_r <= 1'b0;
        tmo_r <= TIMEOUT_CYC;
        ival_r <= 2'h0;
        gap_r <= 1'b0;
        tclk_r <= 8'h00;
        tcnt_r <= {6'h00, ival_len(2'h0)};
      end else if (state_nxt == `UAMS_ST_SLEEP ||
                   state_nxt == `UAMS_ST_READY) begin
        tx_out <= 1'b0;
        start_out <= 1'b0;
        stop_out <= 1'b0;
      end else if (state_r == `UAMS_ST_TX) begin
        start_out <= 1'b0;
        if (tdiv_r != 8'h00) begin
          tdiv_r <= tdiv_r - 8'h01;
        end else if (half_r != 6'h00) begin
          half_r <= half_r - 6'h01;
          // stretch holds the half at half_r == 2, the final high one only while the phase is unflipped, for a second period
          if (tail_stretch_enable && half_r == 6'h02 && !stretch_r) begin
            stretch_r <= 1'b1;
            tdiv_r <= {TX_HALF[6:0], 1'b0};
          end else begin
            tdiv_r <= TX_HALF;
          end
          if (flip_on && half_r[0] == 1'b0 &&
              half_r[5:1] == tx_pulse_count - phase_flip_position)
            phase_r <= ~phase_r;
          tx_out <= ~half_r[0] ^ phase_r;
          if (half_r == 6'h01)
            tx_out <= 1'b0;
        end
      end else if (state_r == `UAMS_ST_RX) begin
        tx_out <= 1'b0;
        if (tmo_r != {CNT_W{1'b0}})
          tmo_r <= tmo_r - {{(CNT_W-1){1'b0}}, 1'b1};
        if (thr_s)
          armed_r <= 1'b1;
        if (!echo_grouping_select) begin
          stop_out <= 1'b0;
          if (zc_rise && armed_r && stops_r != expected_stop_count) begin
            stop_out <= 1'b1;
            stops_r <= stops_r + 3'h1;
            armed_r <= 1'b0;
          end
        end else begin
          if (zc_rise && armed_r && !group_r &&
              stops_r != expected_stop_count &&
              stops_r != `UAMS_MAX_GROUPS) begin
            stop_out <= 1'b1;
            group_r <= 1'b1;
            stops_r <= stops_r + 3'h1;
          end else if (zc_rise && group_r && !thr_s) begin
            stop_out <= 1'b0;
            group_r <= 1'b0;
            armed_r <= 1'b0;
          end
          if (group_r && thr_s)
            armed_r <= 1'b1;
        end
        if (state_nxt == `UAMS_ST_DONE && stops_r != expected_stop_count)
          error_n <= 1'b0;
      end else if (state_r == `UAMS_ST_TEMP) begin
        start_out <= 1'b0;
        stop_out <= 1'b0;
        tclk_r <= ttick ? 8'h00 : tclk_r + 8'h01;
        if (ttick) begin
          // stop lands on the interval's own last tick
          if (tcnt_r > 1 || (gap_r && tcnt_r != 0)) begin
            tcnt_r <= tcnt_r - 1'b1;
          end else if (!gap_r) begin
            stop_out <= 1'b1;
            gap_r <= 1'b1;
            tcnt_r <= gap_len(ival_len(ival_r));
          end else if (ival_r != `UAMS_TEMP_INTERVALS - 1) begin
            start_out <= 1'b1;
            gap_r <= 1'b0;
            ival_r <= ival_r + 2'h1;
            tcnt_r <= {6'h00, ival_len(ival_r + 2'h1)};
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/uams_defs.vh ***
// constants for the ultrasonic measurement sequencer
`ifndef UAMS_DEFS_VH
`define UAMS_DEFS_VH
`define UAMS_ST_SLEEP 3'h0
`define UAMS_ST_READY 3'h1
`define UAMS_ST_TX 3'h2
`define UAMS_ST_RX 3'h3
`define UAMS_ST_TEMP 3'h4
`define UAMS_ST_DONE 3'h5
`define UAMS_PH_FLIP_OFF 5'h1f
`define UAMS_TEMP_DIV 8
`define UAMS_TEMP_GAP_BASE 51
`define UAMS_TEMP_GAP_NUM 11
`define UAMS_TEMP_GAP_DEN 20
`define UAMS_TEMP_INTERVALS 3
`define UAMS_MAX_GROUPS 3'h7
`endif

// *** rtl/uams_sync.v ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module uams_sync (
  // clock and reset
  input wire clock,
  input wire rstn,
  input wire ce,
  // data
  input wire din,
  output reg dout
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // change counts only once stages two and three agree
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/uams_props.sv ***
// assertion checker for the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module uams_props (
  // clock and reset
  input wire clock,
  input wire rstn,
  input wire ce,
  // pins and mode
  input wire wake_pin,
  input wire reset_pin,
  input wire measurement_select,
  input wire echo_grouping_select,
  // outputs
  input wire tx_out,
  input wire start_out,
  input wire stop_out,
  input wire config_ready,
  input wire busy,
  input wire [2:0] state_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence launch_s;
    $rose(busy);
  endsequence
  sequence finish_s;
    state_out == 3'h5;
  endsequence
  mode_pick_a: assert property (launch_s |->
    state_out == (measurement_select ? 3'h4 : 3'h2)) else $error("mode");
  start_launch_a: assert property (launch_s |-> start_out)
    else $error("start");
  start_pulse_a: assert property (start_out |=> !start_out)
    else $error("start width");
  stop_pulse_a: assert property (stop_out && !echo_grouping_select
    |=> !stop_out) else $error("stop width");
  group_hold_a: assert property ($rose(stop_out) && echo_grouping_select
    && !measurement_select |=> stop_out) else $error("group stop width");
  sleep_after_a: assert property (finish_s |=> state_out == 3'h0)
    else $error("sleep");
  idle_cfg_a: assert property (config_ready |-> !busy)
    else $error("config");
  tx_idle_a: assert property (!busy |-> !tx_out)
    else $error("tx idle");
  wake_abort_a: assert property ((ce && !wake_pin)[*8] |->
    state_out == 3'h0) else $error("wake");
  reset_abort_a: assert property ((ce && reset_pin)[*8] |-> !busy)
    else $error("reset");
endmodule
`default_nettype wire

// *** sim/uams_host.sv ***
// host model: wake, trigger, reset pins and pulse stamps
`timescale 1ns/1ps
`default_nettype none
module uams_host (
  // clock and device outputs
  input wire clock,
  input wire start_out,
  input wire stop_out,
  // device pins
  output logic wake_pin,
  output logic trigger_pin,
  output logic reset_pin,
  // counts and last stamps
  output int starts,
  output int stops,
  output int t_start,
  output int t_stop
);
  int cyc;
  logic stop_q;
  initial begin
    {wake_pin, trigger_pin, reset_pin, stop_q} = 4'h0;
    {cyc, starts, stops, t_start, t_stop} = '0;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    stop_q <= stop_out;
    if (start_out) begin
      starts <= starts + 1;
      t_start <= cyc;
    end
    if (stop_out && !stop_q) begin
      stops <= stops + 1;
      t_stop <= cyc;
    end
  end
  task clear;
    starts = 0;
    stops = 0;
  endtask
  // a full pulse carries both edges, so either polarity fires
  task pulse;
    @(posedge clock) #1 trigger_pin = 1'b1;
    repeat (8) @(posedge clock);
    #1 trigger_pin = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, rstn, ce, trig_falling_select, measurement_select;
  logic single_rtd_select, rtd_type_select, phase_flip_enable;
  logic zero_cross, above_threshold, tx_q, echo_grouping_select;
  logic [4:0] tx_pulse_count, phase_flip_position;
  logic [15:0] rtd_ref_cycles, rtd1_cycles, rtd2_cycles;
  logic [2:0] qualify_threshold_level, threshold_dac, state_out;
  wire wake_pin, trigger_pin, reset_pin;
  logic tx_out, start_out, stop_out, error_n, config_ready, busy;
  int starts, stops, t_start, t_stop, tx_cnt, err_count, checks;
  uams_top #(.TIMEOUT_CYC(16'h0100)) dut (.clock, .rstn, .ce,
    .wake_pin, .trigger_pin, .reset_pin, .measurement_select,
    .trig_falling_select, .temp_clock_divider_select(1'b0),
    .tx_clock_div(8'h08), .single_rtd_select, .rtd_type_select,
    .tx_pulse_count, .phase_flip_enable, .phase_flip_position,
    .tail_stretch_enable(1'b0), .echo_grouping_select,
    .expected_stop_count(3'h3), .qualify_threshold_level,
    .zero_cross, .above_threshold, .rtd_ref_cycles, .rtd1_cycles,
    .rtd2_cycles, .tx_out, .start_out, .stop_out, .error_n,
    .threshold_dac, .config_ready, .busy, .state_out);
  uams_host host (.clock, .start_out, .stop_out, .wake_pin,
    .trigger_pin, .reset_pin, .starts, .stops, .t_start, .t_stop);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    tx_q <= tx_out;
    if (tx_out && !tx_q) tx_cnt <= tx_cnt + 1;
  end
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task check(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: got %0h want %0h", $time, s, e);
    end
  endtask
  task conclude;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (state_out !== s) begin
      tick(1);
      if (++n > 20000) begin
        err_count++;
        $display("mismatch at %0t: state wait", $time);
        conclude;
      end
    end
  endtask
  // comparator levels held long enough to pass the synchronisers
  task echo(input logic q);
    above_threshold = q;
    tick(6);
    above_threshold = 1'b0;
    zero_cross = 1'b1;
    tick(6);
    zero_cross = 1'b0;
    tick(6);
  endtask
  task t_boot;
    check(state_out, 3'h0);
    check(config_ready, 1'b1);
    host.wake_pin = 1'b1;
    tick(8);
    check(state_out, 3'h1);
    host.wake_pin = 1'b0;
    tick(8);
    host.pulse;
    tick(8);
    check(state_out, 3'h0);
    check(starts, 0);
    check(threshold_dac, 3'h2);
    host.wake_pin = 1'b1;
    wait_st(3'h1);
    // clock enable low: a wake drop must not be seen
    ce = 1'b0;
    host.wake_pin = 1'b0;
    tick(8);
    check(state_out, 3'h1);
    ce = 1'b1;
    tick(8);
    check(state_out, 3'h0);
    host.wake_pin = 1'b1;
    wait_st(3'h1);
    $display("test boot done");
  endtask
  task run_tof(input logic [4:0] n, pos, input logic fen,
      input int nq, etx);
    tx_pulse_count = n;
    phase_flip_position = pos;
    phase_flip_enable = fen;
    tx_cnt = 0;
    host.clear;
    host.pulse;
    wait_st(3'h3);
    echo(1'b0);
    // a quiet crossing after each echo closes a group
    repeat (nq) begin
      echo(1'b1);
      echo(1'b0);
    end
    wait_st(3'h1);
    check(tx_cnt, etx);
    check(starts, 1);
    check(stops, nq);
    check(error_n, nq >= 3);
    $display("test tof done at %0t", $time);
  endtask
  task run_temp(input logic sg, ty, input int exp);
    measurement_select = 1'b1;
    single_rtd_select = sg;
    rtd_type_select = ty;
    host.clear;
    host.pulse;
    wait_st(3'h1);
    check(starts, 3);
    check(stops, 3);
    check((t_stop - t_start + 4) >> 3, exp);
    measurement_select = 1'b0;
    $display("test temp done at %0t", $time);
  endtask
  initial begin
    {rstn, trig_falling_select, measurement_select} = 3'h0;
    {single_rtd_select, rtd_type_select, phase_flip_enable} = 3'h0;
    {zero_cross, above_threshold, tx_q, echo_grouping_select} = 4'h0;
    {tx_cnt, err_count, checks} = '0;
    ce = 1'b1;
    tx_pulse_count = 5'h05;
    phase_flip_position = 5'h1f;
    qualify_threshold_level = 3'h2;
    rtd_ref_cycles = 16'h0010;
    rtd1_cycles = 16'h0014;
    rtd2_cycles = 16'h0018;
    tick(2);
    rstn = 1'b1;
    tick(8);
    t_boot;
    run_tof(5'h05, 5'h1f, 1'b0, 3, 5);
    run_tof(5'h08, 5'h04, 1'b1, 3, 7);
    trig_falling_select = 1'b1;
    run_tof(5'h08, 5'h1f, 1'b1, 3, 8);
    trig_falling_select = 1'b0;
    run_tof(5'h03, 5'h1f, 1'b0, 1, 3);
    echo_grouping_select = 1'b1;
    run_tof(5'h05, 5'h1f, 1'b0, 3, 5);
    echo_grouping_select = 1'b0;
    run_temp(1'b0, 1'b0, 16'h18);
    run_temp(1'b1, 1'b0, 16'h14);
    run_temp(1'b1, 1'b1, 16'h14);
    measurement_select = 1'b1;
    host.pulse;
    tick(20);
    host.reset_pin = 1'b1;
    tick(10);
    check(busy, 1'b0);
    host.reset_pin = 1'b0;
    measurement_select = 1'b0;
    wait_st(3'h1);
    $display("test abort done");
    conclude;
  end
endmodule
bind uams_top uams_props chk (.clock, .rstn, .ce, .wake_pin,
  .reset_pin, .measurement_select, .echo_grouping_select, .tx_out,
  .start_out, .stop_out, .config_ready, .busy, .state_out);
`default_nettype wire
